//--- gfc_params.svh
// constants for the gated frequency counter
`ifndef GFC_PARAMS_SVH
`define GFC_PARAMS_SVH
`define GFC_CLK_HZ 20000000
`define GFC_CNT_W 16
`define GFC_THR_W 32
`define GFC_TMR_W 28
`define GFC_SEL_W 3
`define GFC_SEL_0S1 3'h0
`define GFC_SEL_0S5 3'h1
`define GFC_SEL_1S0 3'h2
`define GFC_SEL_2S0 3'h3
`define GFC_SEL_5S0 3'h4
`define GFC_SEL_10S0 3'h5
`define GFC_GATE_MS_0S1 100
`define GFC_GATE_MS_0S5 500
`define GFC_GATE_MS_1S0 1000
`define GFC_GATE_MS_2S0 2000
`define GFC_GATE_MS_5S0 5000
`define GFC_GATE_MS_10S0 10000
`define GFC_GATE_CYC(ms) ((`GFC_CLK_HZ / 1000) * (ms))
`define GFC_GATE_CYC_HZ(hz, ms) (((hz) / 1000) * (ms))
`define GFC_MUL_0S1 100
`define GFC_MUL_0S5 20
`define GFC_MUL_1S0 10
`define GFC_MUL_2S0 5
`define GFC_MUL_5S0 2
`define GFC_MUL_10S0 1
`define GFC_DIV_2S0 2
`endif

//--- gfc_pkg.sv
// types for the gated frequency counter
package gfc_pkg;
	typedef enum logic [1:0] {
		GFC_IDLE = 2'b01,
		GFC_GATE = 2'b10
	} gfc_state_t;
endpackage : gfc_pkg

//--- gfc_counter.sv
// gated pulse frequency counter, one instance per fixed input pin
`timescale 1ns/10ps
`include "gfc_params.svh"
module gfc_counter
#(
	parameter int CLK_HZ = `GFC_CLK_HZ
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic count_input_1,
	input wire logic enable,
	input wire logic enable_gating,
	input wire logic [`GFC_SEL_W-1:0] gate_period,
	input wire logic signed [`GFC_THR_W-1:0] upper_threshold,
	input wire logic signed [`GFC_THR_W-1:0] lower_threshold,
	output logic [`GFC_CNT_W-1:0] pulse_count_out,
	output logic [`GFC_CNT_W-1:0] freq_tenths_out,
	output logic upper_limit_flag,
	output logic lower_limit_flag,
	output logic zero_value_flag
);
	import gfc_pkg::*;

	// gate lengths in clock cycles for each interval
	localparam int GATE_0S1 = `GFC_GATE_CYC_HZ(CLK_HZ, `GFC_GATE_MS_0S1);
	localparam int GATE_0S5 = `GFC_GATE_CYC_HZ(CLK_HZ, `GFC_GATE_MS_0S5);
	localparam int GATE_1S0 = `GFC_GATE_CYC_HZ(CLK_HZ, `GFC_GATE_MS_1S0);
	localparam int GATE_2S0 = `GFC_GATE_CYC_HZ(CLK_HZ, `GFC_GATE_MS_2S0);
	localparam int GATE_5S0 = `GFC_GATE_CYC_HZ(CLK_HZ, `GFC_GATE_MS_5S0);
	localparam int GATE_10S0 = `GFC_GATE_CYC_HZ(CLK_HZ, `GFC_GATE_MS_10S0);

	gfc_state_t state_reg, state_next;
	logic sync1_reg, sync1_next, sync2_reg, sync2_next, prev_reg, prev_next;
	logic [`GFC_TMR_W-1:0] tmr_reg, tmr_next, gate_len;
	logic [`GFC_CNT_W-1:0] acc_reg, acc_next, cnt_reg, cnt_next, frq_reg, frq_next, tenfold;
	logic [`GFC_SEL_W-1:0] sel_reg, sel_next;
	logic upf_reg, upf_next, lof_reg, lof_next, zef_reg, zef_next;
	logic run, rise, gate_end;
	logic [`GFC_CNT_W-1:0] acc_inc, meas;
	logic signed [`GFC_THR_W-1:0] meas_s;
	logic up_cmp, lo_cmp, ze_cmp;

	assign run = enable_gating ? enable : 1'b1;
	assign rise = sync2_reg & ~prev_reg;

	// pin synchroniser and edge history
	always_comb
	begin
		sync1_next = count_input_1;
		sync2_next = sync1_reg;
		prev_next = sync2_reg;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			prev_reg <= prev_next;
		end
	end

	always_comb
	begin
		unique case (sel_reg)
			`GFC_SEL_0S5: gate_len = `GFC_TMR_W'(GATE_0S5);
			`GFC_SEL_1S0: gate_len = `GFC_TMR_W'(GATE_1S0);
			`GFC_SEL_2S0: gate_len = `GFC_TMR_W'(GATE_2S0);
			`GFC_SEL_5S0: gate_len = `GFC_TMR_W'(GATE_5S0);
			`GFC_SEL_10S0: gate_len = `GFC_TMR_W'(GATE_10S0);
			default: gate_len = `GFC_TMR_W'(GATE_0S1);
		endcase
	end

	assign acc_inc = acc_reg + `GFC_CNT_W'(rise);
	assign gate_end = (state_reg == GFC_GATE) && (tmr_reg == gate_len - `GFC_TMR_W'(1));

	// tenfold frequency, independent of gate length
	always_comb
	begin
		unique case (sel_reg)
			`GFC_SEL_0S5: tenfold = `GFC_CNT_W'(acc_inc * `GFC_MUL_0S5);
			`GFC_SEL_1S0: tenfold = `GFC_CNT_W'(acc_inc * `GFC_MUL_1S0);
			`GFC_SEL_2S0: tenfold = `GFC_CNT_W'(acc_inc * `GFC_MUL_2S0);
			`GFC_SEL_5S0: tenfold = `GFC_CNT_W'(acc_inc * `GFC_MUL_5S0);
			`GFC_SEL_10S0: tenfold = `GFC_CNT_W'(acc_inc * `GFC_MUL_10S0);
			default: tenfold = `GFC_CNT_W'(acc_inc * `GFC_MUL_0S1);
		endcase
	end

	// value the flags are judged on, zero while stopped
	always_comb
	begin
		meas = run ? acc_inc : '0;
		meas_s = $signed({{(`GFC_THR_W - `GFC_CNT_W){1'b0}}, meas});
		up_cmp = (meas_s >= upper_threshold);
		lo_cmp = (meas_s <= lower_threshold);
		ze_cmp = (meas == '0);
	end

	// gate sequencing
	always_comb
	begin
		state_next = state_reg;
		tmr_next = tmr_reg;
		acc_next = acc_reg;
		sel_next = sel_reg;
		if (!run)
		begin
			state_next = GFC_IDLE;
		end
		else
		begin
			unique case (state_reg)
				GFC_IDLE:
				begin
					state_next = GFC_GATE;
					tmr_next = '0;
					acc_next = '0;
					sel_next = gate_period;
				end
				GFC_GATE:
				begin
					tmr_next = tmr_reg + `GFC_TMR_W'(1);
					acc_next = acc_inc;
					if (gate_end)
					begin
						tmr_next = '0;
						acc_next = '0;
						sel_next = gate_period;
					end
				end
			endcase
		end
	end

	// published results and flags
	always_comb
	begin
		cnt_next = cnt_reg;
		frq_next = frq_reg;
		upf_next = upf_reg;
		lof_next = lof_reg;
		zef_next = zef_reg;
		if (!run)
		begin
			cnt_next = '0;
			frq_next = '0;
			upf_next = up_cmp;
			lof_next = lo_cmp;
			zef_next = ze_cmp;
		end
		else if (gate_end)
		begin
			cnt_next = acc_inc;
			frq_next = tenfold;
			upf_next = up_cmp;
			lof_next = lo_cmp;
			zef_next = ze_cmp;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= GFC_IDLE;
			tmr_reg <= '0;
			acc_reg <= '0;
			sel_reg <= `GFC_SEL_0S1;
		end
		else
		begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			acc_reg <= acc_next;
			sel_reg <= sel_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			// no retained values
			cnt_reg <= '0;
			frq_reg <= '0;
			upf_reg <= 1'b0;
			lof_reg <= 1'b0;
			zef_reg <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_next;
			frq_reg <= frq_next;
			upf_reg <= upf_next;
			lof_reg <= lof_next;
			zef_reg <= zef_next;
		end
	end

	assign pulse_count_out = cnt_reg;
	assign freq_tenths_out = frq_reg;
	assign upper_limit_flag = upf_reg;
	assign lower_limit_flag = lof_reg;
	assign zero_value_flag = zef_reg;
endmodule : gfc_counter

//--- gfc_counter_checker.sv
// assertions on the gated frequency counter ports
`timescale 1ns/10ps
`include "gfc_params.svh"
module gfc_counter_checker
(
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic enable_gating,
	input wire logic signed [`GFC_THR_W-1:0] upper_threshold,
	input wire logic signed [`GFC_THR_W-1:0] lower_threshold,
	input wire logic [`GFC_CNT_W-1:0] pulse_count_out,
	input wire logic [`GFC_CNT_W-1:0] freq_tenths_out,
	input wire logic upper_limit_flag,
	input wire logic lower_limit_flag,
	input wire logic zero_value_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire signed [`GFC_THR_W-1:0] v = {16'h0, pulse_count_out};
	wire off = enable_gating && !enable;
	AST_ZERO: assert property (zero_value_flag == (v == 0)) else $error("zero flag");
	AST_FZ: assert property ((freq_tenths_out == 16'h0) == (v == 0)) else $error("freq zero");
	AST_UPPER: assert property ($changed(v) |-> upper_limit_flag == (v >= upper_threshold)) else $error("upper");
	AST_LOWER: assert property ($changed(v) |-> lower_limit_flag == (v <= lower_threshold)) else $error("lower");
	AST_OFF: assert property (off ##1 off |-> v == 0 && freq_tenths_out == 16'h0) else $error("off");
	AST_START: assert property ($rose(enable) && enable_gating |=> $stable(v) [*8]) else $error("start");
	AST_HOLD: assert property ($changed(v) && !off |=> $stable(v) || off) else $error("hold");
	AST_FHOLD: assert property ($changed(v) && !off |=> $stable(freq_tenths_out) || off) else $error("fhold");
	cover property ($changed(v) && v != 0);
	cover property (off ##1 off);
	cover property ($rose(enable));
endmodule : gfc_counter_checker
bind gfc_counter gfc_counter_checker u_chk (.*);

//--- gfc_pulse_src.sv
// square wave pulse source, low once stopped after finishing its current period
`timescale 1ns/10ps
module gfc_pulse_src
#(
	parameter int HALF_NS = 1000
)
(
	input wire logic run,
	output logic pulse
);
	initial pulse = 1'b0;
	always
	begin
		wait (run);
		#HALF_NS pulse = 1'b1;
		#HALF_NS pulse = 1'b0;
	end
endmodule : gfc_pulse_src

//--- tb_gfc_counter.sv
// testbench for the gated frequency counter
`timescale 1ns/10ps
`include "gfc_params.svh"
module tb_gfc_counter;
	localparam int SIM_HZ = 2000; // scaled clock rate so every interval fits the run
	localparam int SRC_HZ = 50;
	localparam int HALF_NS = (SIM_HZ / SRC_HZ) * 25;
	logic clk, rst, run, count_input_1, enable, enable_gating, upper_limit_flag, lower_limit_flag, zero_value_flag;
	logic [`GFC_SEL_W-1:0] gate_period;
	logic signed [`GFC_THR_W-1:0] upper_threshold, lower_threshold;
	logic [`GFC_CNT_W-1:0] pulse_count_out, freq_tenths_out;
	int num_errors, check_count, seed, k, n, len, cyc;
	int sel_q[$] = '{`GFC_SEL_0S1, `GFC_SEL_0S5, `GFC_SEL_1S0, `GFC_SEL_2S0, `GFC_SEL_5S0, `GFC_SEL_10S0};
	int ms_q[$] = '{`GFC_GATE_MS_0S1, `GFC_GATE_MS_0S5, `GFC_GATE_MS_1S0, `GFC_GATE_MS_2S0, `GFC_GATE_MS_5S0,
		`GFC_GATE_MS_10S0};
	gfc_counter #(.CLK_HZ(SIM_HZ)) u_dut (.*);
	gfc_pulse_src #(.HALF_NS(HALF_NS)) u_src (.run(run), .pulse(count_input_1));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		num_errors += (seen !== exp);
		if (seen !== exp) $display("Error %0t seen %h exp %h", $time, seen, exp);
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	// model of outputs for n pulses and tenfold frequency f
	task automatic expect_out(input int n, input int f);
		check(pulse_count_out, n);
		check(freq_tenths_out, f);
		check(upper_limit_flag, n >= upper_threshold);
		check(lower_limit_flag, n <= lower_threshold);
		check(zero_value_flag, n == 0);
	endtask : expect_out
	// edges until the count output leaves zero, bounded
	task automatic wait_result(input int limit);
		cyc = 0;
		while (cyc < limit && pulse_count_out === 16'h0)
		begin
			@(posedge clk);
			#2;
			cyc++;
		end
		if (cyc >= limit) num_errors++;
	endtask : wait_result
	initial
	begin
		seed = 96160;
		rst = 1'b1;
		run = 1'b0;
		enable = 1'b0;
		enable_gating = 1'b1;
		gate_period = `GFC_SEL_0S1;
		upper_threshold = $random(seed) % 600;
		lower_threshold = $random(seed) % 600;
		repeat (12) @(posedge clk);
		#2 rst = 1'b0;
		run = 1'b1;
		repeat (20) @(posedge clk);
		#2 expect_out(0, 0);
		for (k = 0; k < 6; k++)
		begin
			n = SRC_HZ * ms_q[k] / 1000;
			len = (SIM_HZ / 1000) * ms_q[k];
			gate_period = `GFC_SEL_W'(sel_q[k]);
			upper_threshold = n - 2 + $random(seed) % 5;
			lower_threshold = n - 2 + $random(seed) % 5;
			enable = 1'b1;
			wait_result(len + 8);
			check(cyc, len + 1);
			expect_out(n, SRC_HZ * 10);
			repeat (8) @(posedge clk);
			#2 expect_out(n, SRC_HZ * 10);
			enable = 1'b0;
			repeat (2) @(posedge clk);
			#2 expect_out(0, 0);
		end
		n = SRC_HZ * ms_q[0] / 1000;
		len = (SIM_HZ / 1000) * ms_q[0];
		gate_period = `GFC_SEL_0S1;
		upper_threshold = n - 2 + $random(seed) % 5;
		lower_threshold = n - 2 + $random(seed) % 5;
		enable_gating = 1'b0;
		wait_result(len + 8);
		check(cyc, len + 1);
		expect_out(n, SRC_HZ * 10);
		rst = 1'b1;
		repeat (12) @(posedge clk);
		#2 rst = 1'b0;
		check(pulse_count_out, 0);
		check(zero_value_flag, 1);
		check(upper_limit_flag, 0);
		check(lower_limit_flag, 0);
		repeat (2) @(posedge clk);
		#2 check(freq_tenths_out, 0);
		check(zero_value_flag, 1);
		wait_result(len + 8);
		check(cyc, len - 1);
		expect_out(n, SRC_HZ * 10);
		enable_gating = 1'b1;
		repeat (2) @(posedge clk);
		#2 expect_out(0, 0);
		tally_and_finish();
	end
endmodule : tb_gfc_counter
